/* File: hdl/mviw_pkg.sv */
package mviw_pkg;

    // Source and vector counts of the controller.
    localparam int NUM_SRC = 40;
    localparam int NUM_VEC = 10;

    // Priority level codes, ordered so that a larger code wins.
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_TOP  = 2'h3;

    // Vector addresses: address of the first vector; vecAddr adds the spacing.
    localparam logic [19:0] VEC_BASE = 20'h00003;

    // Vectors below this index may be raised to the top level, the rest only to high.
    localparam int TOP_CAPABLE_VECS = 2;

    // First source index of each vector; sources are numbered vector by vector.
    localparam int VEC_FIRST_SRC [NUM_VEC] = '{0, 1, 2, 7, 10, 15, 20, 22, 26, 33};

    // Named sources that steer the shared vectors and the standby release.
    localparam int SRC_EXT_ZERO       = 0;
    localparam int SRC_EXT_ONE        = 1;
    localparam int SRC_EXT_TWO        = 2;
    localparam int SRC_T0_LOW_BYTE    = 3;
    localparam int SRC_EXT_FOUR       = 4;
    localparam int SRC_USB_BUS_ACTIVE = 5;
    localparam int SRC_IR_RECEIVE     = 6;
    localparam int SRC_EXT_FIVE       = 8;
    localparam int SRC_BASE_TIMER     = 9;
    localparam int SRC_T0_HIGH_BYTE   = 10;
    localparam int SRC_EXT_SIX        = 11;
    localparam int SRC_USB_ATTACH     = 12;
    localparam int SRC_USB_DETACH     = 13;
    localparam int SRC_USB_RESUME     = 14;
    localparam int SRC_SERIAL_ONE     = 22;
    localparam int SRC_SERIAL_FOUR    = 23;
    localparam int SRC_ASYNC_TX       = 24;
    localparam int SRC_AUDIO_END      = 25;
    localparam int SRC_PORT_ZERO      = 33;

    // Standby states of the core.
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_IDLE = 2'b01,
        ST_DEEP = 2'b10,
        ST_XTAL = 2'b11
    } mviw_standby_t;

    // Vector that a source feeds.
    function automatic logic [3:0] srcVec(input int src);
        logic [3:0] v;
        v = 4'h0;
        for (int k = 1; k < NUM_VEC; k++) begin
            if (src >= VEC_FIRST_SRC[k]) begin
                v = 4'(k);
            end
        end
        return v;
    endfunction

    // Level of a vector from its raise bit.
    function automatic logic [1:0] vecLevel(input logic [3:0] idx, input logic raised);
        logic [1:0] l;
        l = LVL_LOW;
        if (raised) begin
            l = (int'(idx) < TOP_CAPABLE_VECS) ? LVL_TOP : LVL_HIGH;
        end
        return l;
    endfunction

    // Entry address of a vector; vectors sit eight bytes apart.
    function automatic logic [19:0] vecAddr(input logic [3:0] idx);
        return VEC_BASE + {13'h0000, idx, 3'h0};
    endfunction

endpackage

/* File: hdl/mviw_arb_if.sv */
`timescale 1ns/1ps
interface mviw_arb_if;
    logic [9:0] vecPend;
    logic [9:0] vecRaised;
    logic       grantValid;
    logic [3:0] grantIdx;
    logic [1:0] grantLvl;

    modport arb (input vecPend, input vecRaised, output grantValid, output grantIdx,
                 output grantLvl);
    modport ctl (output vecPend, output vecRaised, input grantValid, input grantIdx,
                 input grantLvl);
endinterface

/* File: hdl/mviw_arbiter.sv */
`timescale 1ns/1ps
module mviw_arbiter
    import mviw_pkg::*;
(
    mviw_arb_if.arb bus
);

    // Scan from the largest vector down so that an equal level taken later is the smaller
    // vector; a strictly higher level always replaces the current pick.
    always_comb begin
        logic [1:0] lvl;
        lvl = LVL_NONE;
        bus.grantValid = 1'b0;
        bus.grantIdx   = 4'h0;
        bus.grantLvl   = LVL_NONE;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            lvl = vecLevel(4'(i), bus.vecRaised[i]);
            if (bus.vecPend[i] && (lvl >= bus.grantLvl)) begin
                bus.grantValid = 1'b1;
                bus.grantIdx   = 4'(i);
                bus.grantLvl   = lvl;
            end
        end
    end

endmodule

/* File: hdl/mviw_top.sv */
// Behaviour
// - Three nested levels, top above high above low.
// - A request at or below the level in service is withheld.
// - Among different pending vectors the highest level is granted first.
// - Equal levels: the smallest vector address is granted first.
// - Forty sources are gathered onto ten vector addresses.
// - Vector 00013H: pins two and four, timer-0 low, bus activity, infrared.
// - Vector 00023H: timer-0 high, pin six, attach, detach, resume.
// - Vector 0003BH: serial one, serial four, async transmit, audio end.
// - Idle standby stops the core; reset or any interrupt ends it.
// - Deep stop ends on reset pin, pins 0/1/2/4/5, port 0, bus activity.
// - Crystal deep stop also ends on base timer or infrared requests.
// - Deep stop halts PLL reference, all oscillators and all peripherals.
// - Crystal deep stop keeps crystal state and base timer running.
`timescale 1ns/1ps
module mviw_top
    import mviw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [39:0] srcReq,
    input  wire logic [39:0] swClear,
    input  wire logic [9:0]  vecRaised,
    input  wire logic        cpuAck,
    input  wire logic        cpuReturn,
    input  wire logic        idleReq,
    input  wire logic        deepReq,
    input  wire logic        xtalDeepReq,
    input  wire logic        rstPin_n,
    input  wire logic [4:0]  wakePin,
    input  wire logic        xtalEnable,
    output logic             irqValid,
    output logic [19:0]      irqVecAddr,
    output logic [1:0]       irqLevel,
    output logic [1:0]       curLevel,
    output logic [39:0]      srcPending,
    output logic             cpuHalted,
    output logic             periphRun,
    output logic             baseTimerRun,
    output logic             pllRun,
    output logic             ceramicRun,
    output logic             rcRun,
    output logic             xtalRun
);

    mviw_arb_if    arbBus ();
    mviw_standby_t state;
    logic [3:0]    irqIdx;
    logic [2:0]    inSvc;
    logic [2:0]    next_inSvc;
    logic          xtalHeld;
    logic          rstPinMeta;
    logic          rstPinSync;
    logic [4:0]    wakePinMeta;
    logic [4:0]    wakePinSync;
    logic          ackTake;
    logic [39:0]   ackMask;
    logic [39:0]   live;
    logic          deepWake;
    logic          xtalWake;
    logic          betterExists;

    mviw_arbiter u_arbiter (
        .bus (arbBus)
    );

    // Pins come from outside the clock domain, so each crosses two flip-flops first.
    always_ff @(posedge clk) begin
        if (rst) begin
            rstPinMeta  <= 1'b1;
            rstPinSync  <= 1'b1;
            wakePinMeta <= 5'h00;
            wakePinSync <= 5'h00;
        end else begin
            rstPinMeta  <= rstPin_n;
            rstPinSync  <= rstPinMeta;
            wakePinMeta <= wakePin;
            wakePinSync <= wakePinMeta;
        end
    end

    // Fold the pending sources onto their vectors and build the clear mask of a taken vector.
    always_comb begin
        arbBus.vecPend   = 10'h000;
        arbBus.vecRaised = vecRaised;
        ackMask          = 40'h00_0000_0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            arbBus.vecPend[srcVec(i)] = arbBus.vecPend[srcVec(i)] | srcPending[i];
            ackMask[i] = ackTake && (srcVec(i) == irqIdx);
        end
    end

    assign ackTake = cpuAck && irqValid;

    // Pending latches; a new request in the clearing cycle wins so it is never lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            srcPending <= 40'h00_0000_0000;
        end else begin
            srcPending <= (srcPending & ~(swClear | ackMask)) | srcReq;
        end
    end

    // Next in-service set: a return pops the highest level first, then a take pushes its
    // own, so a return and a take in one cycle swap the level in service.
    always_comb begin
        next_inSvc = inSvc;
        if (cpuReturn) begin
            if (inSvc[2]) begin
                next_inSvc[2] = 1'b0;
            end else if (inSvc[1]) begin
                next_inSvc[1] = 1'b0;
            end else begin
                next_inSvc[0] = 1'b0;
            end
        end
        if (ackTake) begin
            next_inSvc[0] = next_inSvc[0] || (irqLevel == LVL_LOW);
            next_inSvc[1] = next_inSvc[1] || (irqLevel == LVL_HIGH);
            next_inSvc[2] = next_inSvc[2] || (irqLevel == LVL_TOP);
        end
    end

    // In-service stack: one bit per level, so nesting depth is bounded by the level count.
    always_ff @(posedge clk) begin
        if (rst) begin
            inSvc <= 3'h0;
        end else begin
            inSvc <= next_inSvc;
        end
    end

    assign curLevel = inSvc[2] ? LVL_TOP : inSvc[1] ? LVL_HIGH : inSvc[0] ? LVL_LOW : LVL_NONE;

    // Offer the winning vector only above the level in service; the cycle of a take
    // drops the offer so a stale grant is never shown while the latches update.
    always_ff @(posedge clk) begin
        if (rst) begin
            irqValid   <= 1'b0;
            irqIdx     <= 4'h0;
            irqLevel   <= LVL_NONE;
            irqVecAddr <= VEC_BASE;
        end else begin
            irqValid   <= !ackTake && arbBus.grantValid
                          && (arbBus.grantLvl > curLevel);
            irqIdx     <= arbBus.grantIdx;
            irqLevel   <= arbBus.grantLvl;
            irqVecAddr <= vecAddr(arbBus.grantIdx);
        end
    end

    // Release terms; a request counts in the cycle it arrives as well as while pending.
    assign live     = srcPending | srcReq;
    assign deepWake = !rstPinSync || (|wakePinSync) || live[SRC_PORT_ZERO]
                      || live[SRC_USB_BUS_ACTIVE];
    assign xtalWake = deepWake || live[SRC_BASE_TIMER] || live[SRC_IR_RECEIVE];

    // Standby sequencer; a deep request outranks the lighter ones if issued together.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_RUN;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (deepReq) begin
                        state <= ST_DEEP;
                    end else if (xtalDeepReq) begin
                        state <= ST_XTAL;
                    end else if (idleReq) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!rstPinSync || (|live)) begin
                        state <= ST_RUN;
                    end
                end
                ST_DEEP: begin
                    if (deepWake) begin
                        state <= ST_RUN;
                    end
                end
                ST_XTAL: begin
                    if (xtalWake) begin
                        state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // The crystal state is frozen on entry so the crystal deep stop cannot change it.
    always_ff @(posedge clk) begin
        if (rst) begin
            xtalHeld <= 1'b0;
        end else if (state == ST_RUN) begin
            xtalHeld <= xtalEnable;
        end
    end

    // Clock and peripheral run enables decoded from the standby state register and the held crystal state.
    assign cpuHalted    = (state != ST_RUN);
    assign periphRun    = (state == ST_RUN) || (state == ST_IDLE);
    assign baseTimerRun = (state != ST_DEEP);
    assign pllRun       = periphRun;
    assign ceramicRun   = periphRun;
    assign rcRun        = periphRun;
    assign xtalRun      = (state == ST_DEEP) ? 1'b0 : xtalHeld;

    // Helper for checking: any pending vector that should have beaten the arbiter's pick.
    always_comb begin
        logic [1:0] lvl;
        lvl = LVL_NONE;
        betterExists = 1'b0;
        for (int i = 0; i < NUM_VEC; i++) begin
            lvl = vecLevel(4'(i), vecRaised[i]);
            if (arbBus.vecPend[i] && ((lvl > arbBus.grantLvl)
                || ((lvl == arbBus.grantLvl) && (4'(i) < arbBus.grantIdx)))) begin
                betterExists = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_grant_best: assert property (arbBus.grantValid |-> !betterExists)
        else $error("Arbiter pick is not the best pending vector.");

    a_offer_above: assert property (irqValid |-> (irqLevel > curLevel))
        else $error("Offered vector is not above the level in service.");

    a_take_nests: assert property (ackTake |=> (curLevel == $past(irqLevel)) && !irqValid)
        else $error("Taken vector did not become the level in service.");

    a_pend_holds: assert property ((srcPending & ~$past(srcPending)
                                   & ~$past(srcReq)) == 40'h00_0000_0000
                                   and ($past(srcPending) & ~srcPending
                                   & ~$past(swClear | ackMask)) == 40'h00_0000_0000)
        else $error("Pending latch changed without cause.");

    a_take_clears: assert property (ackTake && (srcReq == 40'h00_0000_0000)
                                    |=> !arbBus.vecPend[$past(irqIdx)])
        else $error("Taken vector still pending.");

    a_idle_wake: assert property ((state == ST_IDLE) && (|srcReq) |=> (state == ST_RUN))
        else $error("Idle standby missed an interrupt.");

    a_deep_pin: assert property ((state == ST_DEEP) && !rstPinSync |=> (state == ST_RUN))
        else $error("Deep stop missed the reset pin.");

    a_deep_timer: assert property ((state == ST_DEEP) && !deepWake
                                   |=> (state == ST_DEEP))
        else $error("Deep stop left without a release.");

    a_xtal_wake: assert property ((state == ST_XTAL) && srcReq[SRC_BASE_TIMER]
                                  |=> (state == ST_RUN))
        else $error("Crystal deep stop missed the base timer.");

    a_deep_off: assert property ((state == ST_DEEP)
                                 |-> !pllRun && !ceramicRun && !rcRun
                                 && !xtalRun && !periphRun && !baseTimerRun)
        else $error("A clock or peripheral still runs in deep stop.");

    // The entry edge itself may still load the crystal state, so stability starts one later.
    a_xtal_keep: assert property ((state == ST_XTAL) |-> (xtalRun == xtalHeld)
                                  && baseTimerRun && !periphRun
                                  && ($stable(xtalHeld) || ($past(state) != ST_XTAL)))
        else $error("Crystal deep stop lost crystal state or base timer.");

endmodule

/* File: verif/mviw_cpu_model.sv */
`timescale 1ns/1ps
// Core sequencer stand-in: takes each vector offer after a set number of waiting cycles.
module mviw_cpu_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ackEnable,
    input  wire logic [3:0] ackWait,
    input  wire logic       irqValid,
    output logic            cpuAck
);
    logic [3:0] waitCount;

    // Inputs are read just after the edge so that the offer seen is the settled one.
    // The take is a single-cycle pulse, so one offer is never taken twice.
    initial begin
        cpuAck = 1'b0;
        waitCount = 4'h0;
        forever begin
            @(posedge clk);
            #1;
            if (rst || irqValid !== 1'b1 || cpuAck) begin
                cpuAck = 1'b0;
                waitCount = 4'h0;
            end else if (ackEnable && waitCount >= ackWait) begin
                cpuAck = 1'b1;
            end else begin
                waitCount = waitCount + 4'h1;
            end
        end
    end
endmodule

/* File: verif/multilevel_vectored_interrupt_wakeup_tb_top.sv */
`timescale 1ns/1ps
module multilevel_vectored_interrupt_wakeup_tb_top;
    import mviw_pkg::*;
    logic        clk, rst, cpuAck, cpuReturn, idleReq, deepReq, xtalDeepReq;
    logic        rstPin_n, xtalEnable, irqValid, cpuHalted, periphRun, baseTimerRun;
    logic        pllRun, ceramicRun, rcRun, xtalRun, ackEnable;
    logic [39:0] srcReq, swClear, srcPending;
    logic [9:0]  vecRaised;
    logic [4:0]  wakePin;
    logic [19:0] irqVecAddr;
    logic [1:0]  irqLevel, curLevel;
    logic [3:0]  ackWait;
    int          err_count, checks;
    int          srcs [17] = '{0, 1, 2, 3, 4, 5, 6, 10, 11, 12, 13, 14, 22, 23, 24, 25, 33};
    logic [19:0] adrs [17] = '{20'h00003, 20'h0000b, 20'h00013, 20'h00013, 20'h00013,
        20'h00013, 20'h00013, 20'h00023, 20'h00023, 20'h00023, 20'h00023, 20'h00023,
        20'h0003b, 20'h0003b, 20'h0003b, 20'h0003b, 20'h0004b};

    mviw_top dut (.clk(clk), .rst(rst), .srcReq(srcReq), .swClear(swClear),
        .vecRaised(vecRaised), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .idleReq(idleReq),
        .deepReq(deepReq), .xtalDeepReq(xtalDeepReq), .rstPin_n(rstPin_n),
        .wakePin(wakePin), .xtalEnable(xtalEnable), .irqValid(irqValid),
        .irqVecAddr(irqVecAddr), .irqLevel(irqLevel), .curLevel(curLevel),
        .srcPending(srcPending), .cpuHalted(cpuHalted), .periphRun(periphRun),
        .baseTimerRun(baseTimerRun), .pllRun(pllRun), .ceramicRun(ceramicRun),
        .rcRun(rcRun), .xtalRun(xtalRun));

    mviw_cpu_model cpu (.clk(clk), .rst(rst), .ackEnable(ackEnable), .ackWait(ackWait),
        .irqValid(irqValid), .cpuAck(cpuAck));

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // All stimulus changes one nanosecond after the rising edge.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Summary: %0d checks, %0d errors", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Mode 0 waits for an offer, 1 for a level in service, 2 for the core to run again.
    task automatic waitFor(input int mode, input logic [1:0] lvl);
        int n;
        n = 0;
        while (n < 12 && !((mode == 0 && irqValid === 1'b1) || (mode == 2 && cpuHalted === 1'b0)
               || (mode == 1 && curLevel === lvl))) begin
            tick();
            n++;
        end
        if (n == 12) begin
            err_count++;
            $display("ERROR at %0t: wait in mode %0d ran out", $time, mode);
            finish_test();
        end
    endtask

    task automatic pulse(input int s);
        srcReq[s] = 1'b1;
        tick();
        srcReq = 40'h0;
    endtask

    task automatic clearAll();
        swClear = {40{1'b1}};
        tick();
        swClear = 40'h0;
        tick();
    endtask

    task automatic retLevel(input logic [1:0] lvl);
        cpuReturn = 1'b1;
        tick();
        cpuReturn = 1'b0;
        check(40'(curLevel), 40'(lvl));
        tick();
    endtask

    // Mode 0 is idle, 1 deep stop, 2 crystal-retained deep stop.
    task automatic enter(input int m);
        idleReq = (m == 0);
        deepReq = (m == 1);
        xtalDeepReq = (m == 2);
        tick();
        {idleReq, deepReq, xtalDeepReq} = 3'h0;
    endtask

    // Every listed source lands on its own or shared vector at the low level.
    task automatic scenMap();
        for (int i = 0; i < 17; i++) begin
            pulse(srcs[i]);
            waitFor(0, LVL_NONE);
            check(40'(irqVecAddr), 40'(adrs[i]));
            check(40'(irqLevel), 40'(LVL_LOW));
            clearAll();
        end
    endtask

    // Same-cycle requests: address decides at equal level, level decides otherwise.
    task automatic scenPrio();
        srcReq[22] = 1'b1;
        srcReq[10] = 1'b1;
        tick();
        srcReq = 40'h0;
        waitFor(0, LVL_NONE);
        check(40'(irqVecAddr), 40'h23);
        vecRaised = 10'h080;
        tick();
        tick();
        check(40'({irqValid, irqLevel, irqVecAddr}),
              40'({1'b1, LVL_HIGH, 20'h0003b}));
        clearAll();
        vecRaised = 10'h000;
    endtask

    // Nesting: low in service withholds low, top preempts, returns unwind in order.
    task automatic scenNest();
        vecRaised = 10'h001;
        ackWait = 4'h2;
        ackEnable = 1'b1;
        pulse(10);
        waitFor(1, LVL_LOW);
        check(40'(srcPending[10]), 40'h0);
        pulse(22);
        repeat (3) tick();
        check(40'({irqValid, srcPending[22]}), 40'h1);
        ackWait = 4'h0;
        pulse(0);
        waitFor(1, LVL_TOP);
        ackEnable = 1'b0;
        retLevel(LVL_LOW);
        retLevel(LVL_NONE);
        waitFor(0, LVL_NONE);
        check(40'(irqVecAddr), 40'h3b);
        clearAll();
        vecRaised = 10'h000;
    endtask

    // Standby entry and release for each of the three states.
    task automatic scenStandby();
        enter(0);
        check(40'({cpuHalted, periphRun, baseTimerRun, pllRun, ceramicRun, rcRun, xtalRun}),
              40'h7f);
        pulse(20);
        waitFor(2, LVL_NONE);
        clearAll();
        enter(1);
        check(40'({cpuHalted, periphRun, baseTimerRun, pllRun, ceramicRun, rcRun, xtalRun}),
              40'h40);
        pulse(9);
        tick();
        check(40'(cpuHalted), 40'h1);
        pulse(33);
        waitFor(2, LVL_NONE);
        clearAll();
        enter(1);
        wakePin = 5'h08;
        waitFor(2, LVL_NONE);
        wakePin = 5'h00;
        clearAll();
        enter(2);
        check(40'({cpuHalted, periphRun, baseTimerRun, pllRun, ceramicRun, rcRun, xtalRun}),
              40'h51);
        pulse(6);
        waitFor(2, LVL_NONE);
        clearAll();
    endtask

    // Set beats clear, the reset pin ends idle and deep stop, the base timer ends a crystal
    // stop, and the crystal keeps its entry state while its enable drops.
    task automatic scenWake();
        srcReq[3] = 1'b1;
        swClear[3] = 1'b1;
        tick();
        srcReq = 40'h0;
        check(40'(srcPending[3]), 40'h1);
        clearAll();
        for (int m = 0; m < 2; m++) begin
            enter(m);
            rstPin_n = 1'b0;
            waitFor(2, LVL_NONE);
            rstPin_n = 1'b1;
            repeat (3) tick();
        end
        enter(2);
        xtalEnable = 1'b0;
        tick();
        check(40'({cpuHalted, xtalRun}), 40'h3);
        pulse(9);
        waitFor(2, LVL_NONE);
        tick();
        check(40'(xtalRun), 40'h0);
        xtalEnable = 1'b1;
        clearAll();
    endtask

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        {rst, xtalEnable, rstPin_n} = 3'b111;
        {cpuReturn, idleReq, deepReq, xtalDeepReq, ackEnable} = 5'h0;
        {srcReq, swClear, vecRaised, wakePin, ackWait} = '0;
        err_count = 0;
        checks = 0;
        repeat (2) tick();
        check(40'({irqValid, irqLevel, curLevel}), 40'h0);
        check(srcPending, 40'h0);
        check(40'(irqVecAddr), 40'(VEC_BASE));
        check(40'({cpuHalted, periphRun, baseTimerRun, pllRun, ceramicRun, rcRun, xtalRun}),
              40'h3e);
        rst = 1'b0;
        tick();
        scenMap();
        scenPrio();
        scenNest();
        scenStandby();
        scenWake();
        finish_test();
    end
endmodule
